//--- verilog/mcsp_clock_ctrl.sv
// main clock select, protected divider and start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mcsp_consts.svh"

module mcsp_clock_ctrl
  import mcsp_pkg::*;
#(
  parameter int unsigned RST_TICKS = `MCSP_RST_TICKS
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // reset sources and sleep wake-up
  input  wire logic       rst_src,
  input  wire logic       pd_wake,
  input  wire logic       light_wake,
  // oscillator ticks
  input  wire logic       osc8_tick,
  input  wire logic       osc128_tick,
  input  wire logic       ext_tick,
  input  wire logic [7:0] factory_trim,
  // io register port
  input  wire logic [5:0] io_addr,
  input  wire logic       io_we,
  input  wire logic       io_re,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // clock and reset outputs
  output logic            int_rst,
  output logic            cpu_hold,
  output logic            resume_pulse,
  output logic            main_tick,
  output logic            sys_tick,
  output logic      [1:0] main_src_out,
  output logic      [7:0] osc_trim_out
);

  localparam logic [15:0] RST_LAST = 16'(RST_TICKS - 1);
  localparam logic [4:0]  OSC_LAST = `MCSP_OSC_START_CYC - 5'h01;
  localparam logic [4:0]  NVM_LAST = `MCSP_NVM_LOAD_CYC - 5'h01;

  localparam mcsp_ctl_t CTL_RST = '{
    state:   MCSP_ST_RST_DELAY,
    rst_cnt: 16'h0000,
    cnt:     5'h00,
    src:     `MCSP_SRC_RST,
    act_src: `MCSP_SRC_RST,
    div:     `MCSP_DIV_RST,
    trim:    8'h00,
    win:     3'h0,
    rdata:   8'h00,
    resume:  1'b0
  };

  mcsp_ctl_t   q;
  mcsp_ctl_t   d;
  mcsp_clk_if  ck ();

  logic        ccp_hit;
  logic        wr_src;
  logic        wr_div;
  logic        new_src_tick;

  // selected source tick; act_src moves only on a tick of the new source, or at once on a reset source
  always_comb
  begin
    case (q.act_src)
      `MCSP_SRC_OSC8:   main_tick = osc8_tick;
      `MCSP_SRC_OSC128: main_tick = osc128_tick;
      `MCSP_SRC_EXT:    main_tick = ext_tick;
      default:          main_tick = 1'b0;
    endcase
  end

  always_comb
  begin
    case (q.src)
      `MCSP_SRC_OSC8:   new_src_tick = osc8_tick;
      `MCSP_SRC_OSC128: new_src_tick = osc128_tick;
      `MCSP_SRC_EXT:    new_src_tick = ext_tick;
      default:          new_src_tick = 1'b0;
    endcase
  end

  assign ck.main_tick = main_tick;
  assign ck.clr       = rst_src;
  assign ck.code      = q.div;
  assign sys_tick     = ck.sys_tick;

  mcsp_prescaler u_presc (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .ck       (ck.presc)
  );

  assign ccp_hit = io_we && (io_addr == `MCSP_ADDR_CCP) && (io_wdata == `MCSP_CCP_SIG);
  assign wr_src  = io_we && (io_addr == `MCSP_ADDR_SRC);
  assign wr_div  = io_we && (io_addr == `MCSP_ADDR_DIV);

  always_comb
  begin
    d        = q;
    d.resume = 1'b0;

    // read data, upper bits of source and divider forced low
    d.rdata = 8'h00;
    if (io_re)
    begin
      case (io_addr)
        `MCSP_ADDR_SRC:  d.rdata = {6'h00, q.src};
        `MCSP_ADDR_DIV:  d.rdata = {4'h0, q.div};
        `MCSP_ADDR_TRIM: d.rdata = q.trim;
        default:         d.rdata = 8'h00;
      endcase
    end

    // protected window counts instruction cycles, i.e. system ticks
    if (ccp_hit)
      d.win = `MCSP_WIN_CYCLES;
    else if ((q.win != 3'h0) && sys_tick)
      d.win = q.win - 3'h1;

    // reserved codes are dropped too; the old setting stays
    if (wr_src && (q.win != 3'h0))
    begin
      d.win = 3'h0;
      if (io_wdata[`MCSP_SRC_MSB:0] != `MCSP_SRC_RSVD)
        d.src = io_wdata[`MCSP_SRC_MSB:0];
    end
    if (wr_div && (q.win != 3'h0))
    begin
      d.win = 3'h0;
      if (io_wdata[`MCSP_DIV_MSB:0] <= `MCSP_DIV_MAX)
        d.div = io_wdata[`MCSP_DIV_MSB:0];
    end

    // trim is free to write; higher code gives higher frequency
    if (io_we && (io_addr == `MCSP_ADDR_TRIM))
      d.trim = io_wdata;

    // switch only when the new source ticks, so no runt main tick
    if ((q.src != q.act_src) && new_src_tick)
      d.act_src = q.src;

    case (q.state)
      MCSP_ST_RST_DELAY:
      begin
        if (osc128_tick)
        begin
          d.rst_cnt = q.rst_cnt + 16'h0001;
          if (q.rst_cnt == RST_LAST)
          begin
            d.state = MCSP_ST_OSC_START;
            d.cnt   = 5'h00;
          end
        end
      end
      MCSP_ST_OSC_START:
      begin
        if (osc8_tick)
        begin
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == OSC_LAST)
          begin
            d.state = MCSP_ST_NVM_LOAD;
            d.cnt   = 5'h00;
            d.trim  = factory_trim;
          end
        end
      end
      MCSP_ST_NVM_LOAD:
      begin
        if (sys_tick)
        begin
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == NVM_LAST)
          begin
            d.state = MCSP_ST_RUN;
            d.cnt   = 5'h00;
          end
        end
      end
      MCSP_ST_RUN:
      begin
        if (pd_wake)
        begin
          d.state = MCSP_ST_PD_WAKE;
          d.cnt   = 5'h00;
        end
        else if (light_wake)
          d.resume = 1'b1;
      end
      MCSP_ST_PD_WAKE:
      begin
        if (main_tick)
        begin
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == OSC_LAST)
          begin
            d.state  = MCSP_ST_RUN;
            d.cnt    = 5'h00;
            d.resume = 1'b1;
          end
        end
      end
      default:
      begin
        d.state = MCSP_ST_RST_DELAY;
      end
    endcase

    // any reset source restarts everything; trim reloads later
    if (rst_src)
    begin
      d.state   = MCSP_ST_RST_DELAY;
      d.rst_cnt = 16'h0000;
      d.cnt     = 5'h00;
      d.src     = `MCSP_SRC_RST;
      d.act_src = `MCSP_SRC_RST;
      d.div     = `MCSP_DIV_RST;
      d.win     = 3'h0;
      d.resume  = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= CTL_RST;
    else
      q <= d;
  end

  // reset source reaches the core at once, not a cycle later
  assign int_rst      = rst_src || (q.state == MCSP_ST_RST_DELAY) ||
                        (q.state == MCSP_ST_OSC_START) || (q.state == MCSP_ST_NVM_LOAD);
  assign cpu_hold     = (q.state == MCSP_ST_PD_WAKE);
  assign resume_pulse = q.resume;
  assign io_rdata     = q.rdata;
  assign main_src_out = q.act_src;
  assign osc_trim_out = q.trim;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_src_write_locked: assert property (wr_src && (q.win == 3'h0) && !rst_src |=> $stable(q.src))
    else $error("source changed outside protected window");
  a_div_write_locked: assert property (wr_div && (q.win == 3'h0) && !rst_src |=> $stable(q.div))
    else $error("divider changed outside protected window");
  a_div_window_open: assert property (ccp_hit ##1 !io_we ##1 (wr_div && !rst_src && io_wdata[7:4] == 4'h0
                                      && io_wdata[3:0] <= 4'h8) |=> q.div == $past(io_wdata[3:0]))
    else $error("protected divider write not taken");
  a_reset_defaults: assert property (rst_src |=> (q.div == 4'h3) && (q.src == 2'h0))
    else $error("reset did not restore source and divider");
  a_src_not_rsvd: assert property (q.src != `MCSP_SRC_RSVD)
    else $error("reserved source code held");
  a_div_in_range: assert property (q.div <= `MCSP_DIV_MAX)
    else $error("reserved divider code held");
  a_read_upper_zero: assert property (io_re && (io_addr == `MCSP_ADDR_SRC) |=> io_rdata[7:2] == 6'h00)
    else $error("source register upper bits not zero");
  a_rst_immediate: assert property (rst_src |-> int_rst ##1 (int_rst && q.state == MCSP_ST_RST_DELAY))
    else $error("internal reset not asserted at once");
  a_trim_loaded: assert property ((q.state == MCSP_ST_OSC_START) && osc8_tick && (q.cnt == OSC_LAST)
                                  && !rst_src |=> q.trim == $past(factory_trim))
    else $error("factory trim not loaded");
  a_light_wake_now: assert property ((q.state == MCSP_ST_RUN) && light_wake && !pd_wake && !rst_src
                                     |=> resume_pulse)
    else $error("light sleep wake delayed");
  a_pd_wake_hold: assert property ((q.state == MCSP_ST_RUN) && pd_wake && !rst_src
                                   |=> cpu_hold ##1 cpu_hold)
    else $error("power-down wake did not hold the core");
  a_src_switch_tick: assert property ((q.act_src != $past(q.act_src)) && !$past(rst_src)
                                      |-> $past(new_src_tick))
    else $error("source switched off a new source tick");

  c_reach_run: cover property ((q.state == MCSP_ST_NVM_LOAD) ##1 (q.state == MCSP_ST_RUN));
  c_div_change: cover property (ccp_hit ##2 wr_div);
  c_src_switch: cover property ((q.src != q.act_src) ##1 (q.src == q.act_src));
  c_pd_resume: cover property ((q.state == MCSP_ST_PD_WAKE) ##1 resume_pulse);

endmodule

`default_nettype wire

//--- common/mcsp_consts.svh
// constants for main clock select, prescaler and start-up control
`ifndef MCSP_CONSTS_SVH
`define MCSP_CONSTS_SVH

// register offsets in the io space
`define MCSP_ADDR_DIV        6'h36
`define MCSP_ADDR_SRC        6'h37
`define MCSP_ADDR_TRIM       6'h39
`define MCSP_ADDR_CCP        6'h3c

// signature that opens the protected window, value arbitrary
`define MCSP_CCP_SIG         8'h5a
// window length in instruction cycles
`define MCSP_WIN_CYCLES      3'h4

// field layout
`define MCSP_SRC_MSB         1
`define MCSP_DIV_MSB         3

// reset values and source codes
`define MCSP_SRC_RST         2'h0
`define MCSP_SRC_OSC8        2'h0
`define MCSP_SRC_OSC128      2'h1
`define MCSP_SRC_EXT         2'h2
`define MCSP_SRC_RSVD        2'h3
`define MCSP_DIV_RST         4'h3
`define MCSP_DIV_MAX         4'h8

// start-up timing
`define MCSP_RST_DELAY_MS    64
`define MCSP_SLOW_OSC_KHZ    128
`define MCSP_RST_TICKS       (`MCSP_RST_DELAY_MS * `MCSP_SLOW_OSC_KHZ)
`define MCSP_OSC_START_CYC   5'h6
`define MCSP_NVM_LOAD_CYC    5'h15

`endif

//--- common/mcsp_pkg.sv
// types for main clock select, prescaler and start-up control
package mcsp_pkg;

  typedef enum logic [4:0] {
    MCSP_ST_RST_DELAY = 5'h01,
    MCSP_ST_OSC_START = 5'h02,
    MCSP_ST_NVM_LOAD  = 5'h04,
    MCSP_ST_RUN       = 5'h08,
    MCSP_ST_PD_WAKE   = 5'h10
  } mcsp_state_t;

  typedef struct packed {
    mcsp_state_t state;
    logic [15:0] rst_cnt;
    logic [4:0]  cnt;
    logic [1:0]  src;
    logic [1:0]  act_src;
    logic [3:0]  div;
    logic [7:0]  trim;
    logic [2:0]  win;
    logic [7:0]  rdata;
    logic        resume;
  } mcsp_ctl_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [3:0] cur;
    logic [3:0] pend;
  } mcsp_presc_t;

endpackage

//--- common/mcsp_clk_if.sv
// main tick, divider code and system tick between control and prescaler
`timescale 1ns/1ps
`default_nettype none

interface mcsp_clk_if;
  logic       main_tick;
  logic       clr;
  logic [3:0] code;
  logic       sys_tick;

  modport ctl   (output main_tick, output clr, output code, input sys_tick);
  modport presc (input main_tick, input clr, input code, output sys_tick);
endinterface

`default_nettype wire

//--- verilog/mcsp_prescaler.sv
// ripple prescaler: divides main ticks into system ticks
`timescale 1ns/1ps
`default_nettype none
`include "mcsp_consts.svh"

module mcsp_prescaler
  import mcsp_pkg::*;
(
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  // control side
  mcsp_clk_if.presc   ck
);

  mcsp_presc_t q;
  mcsp_presc_t d;
  logic [7:0]  mask;
  logic        wrap;

  // counter advances only on main ticks, like a ripple chain on the main clock
  always_comb
  begin
    d    = q;
    mask = 8'((9'h001 << q.cur) - 9'h001);
    wrap = ck.main_tick && ((q.cnt & mask) == mask);
    d.pend = ck.code;
    if (ck.clr)
    begin
      d.cnt = 8'h00;
      d.cur = `MCSP_DIV_RST;
    end
    else if (wrap)
    begin
      // new code only at an old period boundary, so no short pulse appears
      d.cnt = 8'h00;
      d.cur = q.pend;
    end
    else if (ck.main_tick)
    begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  assign ck.sys_tick = wrap;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '{cnt: 8'h00, cur: `MCSP_DIV_RST, pend: `MCSP_DIV_RST};
    else
      q <= d;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_div1_every_tick: assert property ((q.cur == 4'h0) && ck.main_tick |-> ck.sys_tick)
    else $error("divide by one missed a main tick");
  a_no_short_period: assert property (ck.sys_tick && (q.pend != 4'h0) |=> !ck.sys_tick)
    else $error("system tick period shorter than allowed");
  a_switch_at_edge: assert property (ck.sys_tick && !ck.clr |=> q.cur == $past(q.pend))
    else $error("new divider not taken at period boundary");

endmodule

`default_nettype wire

//--- sim/main_clock_select_prescaler_startup_bench.sv
// self-checking bench for main clock select, prescaler and start-up control
`timescale 1ns/1ps
`default_nettype none
`include "mcsp_consts.svh"

module main_clock_select_prescaler_startup_bench;
  // design ports
  logic        core_clk;
  logic        rst_b;
  logic        rst_src, pd_wake, light_wake;
  logic        osc8_tick, osc128_tick, ext_tick;
  logic  [7:0] factory_trim, io_wdata, io_rdata, osc_trim_out;
  logic  [5:0] io_addr;
  logic        io_we, io_re, int_rst, cpu_hold, resume_pulse, main_tick, sys_tick;
  logic  [1:0] main_src_out;
  // bench state
  logic  [7:0] tk = 8'h00;
  int          errors, total_checks;
  logic  [1:0] sc [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic  [1:0] se [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
  logic [15:0] sg [4] = '{16'd5, 16'd3, 16'd3, 16'd2};

  // short start-up count keeps the run small
  mcsp_clock_ctrl #(.RST_TICKS(8)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .rst_src(rst_src), .pd_wake(pd_wake),
    .light_wake(light_wake), .osc8_tick(osc8_tick), .osc128_tick(osc128_tick),
    .ext_tick(ext_tick), .factory_trim(factory_trim), .io_addr(io_addr), .io_we(io_we),
    .io_re(io_re), .io_wdata(io_wdata), .io_rdata(io_rdata), .int_rst(int_rst),
    .cpu_hold(cpu_hold), .resume_pulse(resume_pulse), .main_tick(main_tick),
    .sys_tick(sys_tick), .main_src_out(main_src_out), .osc_trim_out(osc_trim_out));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // oscillator ticks: 8 MHz every 2, slow every 5, external every 3 cycles
  // a 30-cycle wrap keeps all three gaps regular
  always @(posedge core_clk)
  begin
    tk          <= (tk == 8'h1d) ? 8'h00 : tk + 8'h01;
    osc8_tick   <= tk[0];
    osc128_tick <= (tk % 8'h05) == 8'h00;
    ext_tick    <= (tk % 8'h03) == 8'h00;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_we    <= 1'b1;
    io_addr  <= a;
    io_wdata <= d;
    @(posedge core_clk);
    io_we <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    @(posedge core_clk);
    io_re   <= 1'b1;
    io_addr <= a;
    @(posedge core_clk);
    io_re <= 1'b0;
    @(negedge core_clk);
    check(16'(io_rdata), 16'(e));
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: hit = sys_tick;
      1: hit = main_tick;
      default: hit = !int_rst;
    endcase
  endfunction

  // cycles and main ticks up to and including the next hit
  task automatic upto(input int sel, output int cyc, output int mt);
    cyc = 0;
    mt  = 0;
    do
    begin
      @(negedge core_clk);
      cyc++;
      if (main_tick === 1'b1)
        mt++;
    end
    while (hit(sel) !== 1'b1 && cyc < 5000);
    if (hit(sel) !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      stop_test();
    end
  endtask

  task automatic startup();
    int cyc, mt;
    upto(2, cyc, mt);
    check(16'(cyc >= 360), 16'h1);
    check(16'(main_src_out), 16'(`MCSP_SRC_OSC8));
    check(16'(osc_trim_out), 16'h9c);
    rdc(`MCSP_ADDR_DIV, 8'h03);
    rdc(`MCSP_ADDR_SRC, 8'h00);
    upto(0, cyc, mt);
    upto(0, cyc, mt);
    check(16'(mt), 16'd8);
  endtask

  initial
  begin
    int cyc, m1, m2, m3, old;
    {rst_src, pd_wake, light_wake, io_we, io_re} = 5'h00;
    {osc8_tick, osc128_tick, ext_tick} = 3'h0;
    {io_addr, io_wdata} = 14'h0;
    factory_trim = 8'h9c;
    errors       = 0;
    total_checks = 0;
    rst_b        = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check(16'(int_rst), 16'h1);
    startup();
    rdc(6'h3a, 8'h00);
    // refused divider writes: no window, wrong signature, expired window, reserved code
    wr(`MCSP_ADDR_DIV, 8'h00);
    rdc(`MCSP_ADDR_DIV, 8'h03);
    wr(`MCSP_ADDR_CCP, 8'ha5);
    wr(`MCSP_ADDR_DIV, 8'h00);
    rdc(`MCSP_ADDR_DIV, 8'h03);
    wr(`MCSP_ADDR_CCP, `MCSP_CCP_SIG);
    repeat (5) upto(0, cyc, m1);
    wr(`MCSP_ADDR_DIV, 8'h00);
    rdc(`MCSP_ADDR_DIV, 8'h03);
    wr(`MCSP_ADDR_CCP, `MCSP_CCP_SIG);
    wr(`MCSP_ADDR_DIV, 8'h09);
    rdc(`MCSP_ADDR_DIV, 8'h03);
    old = 3;
    for (int k = 0; k <= 8; k++)
    begin
      wr(`MCSP_ADDR_CCP, `MCSP_CCP_SIG);
      wr(`MCSP_ADDR_DIV, 8'(k));
      upto(0, cyc, m1);
      upto(0, cyc, m2);
      upto(0, cyc, m3);
      check(16'(m1 + m2 <= (1 << old) + (1 << k)), 16'h1);
      check(16'(m2 >= (1 << ((old < k) ? old : k))), 16'h1);
      check(16'(m3), 16'(1 << k));
      rdc(`MCSP_ADDR_DIV, 8'(k));
      old = k;
    end
    wr(`MCSP_ADDR_CCP, `MCSP_CCP_SIG);
    wr(`MCSP_ADDR_DIV, 8'h00);
    wr(`MCSP_ADDR_SRC, 8'h01);
    repeat (3) upto(1, cyc, m1);
    check(16'(main_src_out), 16'h0);
    foreach (sc[i])
    begin
      wr(`MCSP_ADDR_CCP, `MCSP_CCP_SIG);
      wr(`MCSP_ADDR_SRC, {6'h00, sc[i]});
      // longer than the slowest source gap, so the switch has surely happened
      repeat (12) @(negedge core_clk);
      check(16'(main_src_out), 16'(se[i]));
      rdc(`MCSP_ADDR_SRC, {6'h00, se[i]});
      upto(1, cyc, m1);
      upto(1, cyc, m1);
      check(16'(cyc), sg[i]);
    end
    foreach (sg[i])
    begin
      wr(`MCSP_ADDR_TRIM, sg[i][7:0] ^ 8'h5a);
      rdc(`MCSP_ADDR_TRIM, sg[i][7:0] ^ 8'h5a);
      check(16'(osc_trim_out), 16'(sg[i][7:0] ^ 8'h5a));
    end
    @(posedge core_clk);
    light_wake <= 1'b1;
    @(posedge core_clk);
    light_wake <= 1'b0;
    @(negedge core_clk);
    check(16'({resume_pulse, cpu_hold}), 16'h2);
    @(posedge core_clk);
    pd_wake <= 1'b1;
    @(posedge core_clk);
    pd_wake <= 1'b0;
    @(negedge core_clk);
    check(16'(cpu_hold), 16'h1);
    // count only ticks seen while the core is held
    m1 = 0;
    for (cyc = 0; cyc < 200 && resume_pulse !== 1'b1; cyc++)
    begin
      if (main_tick === 1'b1 && cpu_hold === 1'b1)
        m1++;
      @(negedge core_clk);
    end
    check(16'(resume_pulse), 16'h1);
    check(16'(m1), 16'd6);
    // leave the external source selected so the reset restore is visible
    wr(`MCSP_ADDR_CCP, `MCSP_CCP_SIG);
    wr(`MCSP_ADDR_SRC, 8'h02);
    repeat (12) @(negedge core_clk);
    check(16'(main_src_out), 16'(`MCSP_SRC_EXT));
    @(posedge core_clk);
    rst_src <= 1'b1;
    @(negedge core_clk);
    check(16'(int_rst), 16'h1);
    repeat (20) @(posedge core_clk);
    rst_src <= 1'b0;
    @(negedge core_clk);
    check(16'(int_rst), 16'h1);
    startup();
    stop_test();
  end
endmodule

`default_nettype wire
